// ===== rtl/rtcdst_pkg.sv
/*
  Shared constants and types of the temperature compensation and seasonal
  shift control block: register offsets, field positions, reset values and
  the packed carriers for calendar state and frequency trims.
  Assumes a serial front end that turns bus traffic into byte register
  accesses, and a calendar core that owns the time counters.
*/
package rtcdst_pkg;

  // Register offsets
  localparam logic [7:0] OFS_INIT_OFFSET = 8'h0B;
  localparam logic [7:0] OFS_TEMP_COEF = 8'h0C;
  localparam logic [7:0] OFS_COMP_CTRL = 8'h0D;
  localparam logic [7:0] OFS_FWD_MONTH = 8'h15;
  localparam logic [7:0] OFS_FWD_WEEKDAY = 8'h16;
  localparam logic [7:0] OFS_FWD_DATE = 8'h17;
  localparam logic [7:0] OFS_FWD_HOUR = 8'h18;
  localparam logic [7:0] OFS_REV_MONTH = 8'h19;
  localparam logic [7:0] OFS_REV_WEEKDAY = 8'h1A;
  localparam logic [7:0] OFS_REV_DATE = 8'h1B;
  localparam logic [7:0] OFS_REV_HOUR = 8'h1C;

  // Compensation control fields
  localparam int CTRL_TSE_BIT = 7;
  localparam int CTRL_BATT_LSB = 5;
  localparam int TRIM_CODE_W = 5;
  localparam logic [2:0] CTRL_TOP_RESET = 3'h0;

  // Seasonal shift fields
  localparam int MONTH_EN_BIT = 7;
  localparam logic [7:0] MONTH_MASK = 8'h1F;
  localparam logic [7:0] HOUR_MASK = 8'h3F;
  localparam int WD_SEL_BIT = 6;
  localparam int WEEK_LSB = 3;
  localparam logic [2:0] WEEK_LAST = 3'h7;
  localparam logic [7:0] SHIFT_REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] TIME_ZERO = 8'h00;

  // Correction period in seconds, the one-second step and days per week
  localparam logic [9:0] COMP_PERIOD_S = 10'h03C;
  localparam logic [9:0] SEC_ONE = 10'h001;
  localparam logic [6:0] DAYS_PER_WEEK = 7'h07;

  typedef enum logic [1:0] {
    BATT_OFF,
    BATT_X1,
    BATT_X2,
    BATT_X4
  } rtcdst_batt_mode_type;

  typedef struct packed {
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
    logic [2:0] weekday;
    logic [4:0] month_days;
  } rtcdst_cal_type;

  typedef struct packed {
    logic [5:0] coarse;
    logic [7:0] fine;
  } rtcdst_trim_type;

  // BCD byte to binary, used for the calendar date in the shift matcher
  function automatic logic [6:0] rtcdst_bcd2bin(input logic [7:0] bcd);
    logic [6:0] tens;
    tens = {3'h0, bcd[7:4]};
    return 7'((tens << 3) + (tens << 1) + {3'h0, bcd[3:0]});
  endfunction : rtcdst_bcd2bin

endpackage : rtcdst_pkg

// ===== rtl/rtcdst_shift_match.sv
/*
  Point matcher for one seasonal shift direction: compares calendar state
  against a month, week/day, date and hour set.
  Assumes calendar fields are BCD and stable for the whole clock cycle.
*/
`timescale 1ns/1ps
module rtcdst_shift_match
  import rtcdst_pkg::*;
(
  // Calendar state
  input wire rtcdst_cal_type cal,
  // Programmed point
  input wire logic [7:0] month_reg,
  input wire logic [7:0] week_day_reg,
  input wire logic [7:0] date_reg,
  input wire logic [7:0] hour_reg,
  // Result
  output logic hit
);

  logic [6:0] date_bin;
  logic [2:0] week_num;
  logic last_week;
  logic day_ok;

  // Week of month from date; last week when a further week overflows
  always_comb begin
    date_bin = rtcdst_bcd2bin(cal.date);
    week_num = 3'((date_bin - 7'h01) / DAYS_PER_WEEK + 7'h01);
    last_week = (date_bin + DAYS_PER_WEEK) > {2'h0, cal.month_days};
  end

  // Week/day or date selection, hour and month plain BCD
  always_comb begin
    if (week_day_reg[WD_SEL_BIT]) begin
      day_ok = (cal.weekday == week_day_reg[2:0]) &&
               ((week_day_reg[WEEK_LSB +: 3] == WEEK_LAST) ? last_week
                : (week_num == week_day_reg[WEEK_LSB +: 3]));
    end else begin
      day_ok = (cal.date == date_reg);
    end
    hit = day_ok && ((cal.month & MONTH_MASK) == (month_reg & MONTH_MASK)) &&
          ((cal.hour & HOUR_MASK) == (hour_reg & HOUR_MASK)) &&
          (cal.minute == TIME_ZERO) && (cal.second == TIME_ZERO);
  end

endmodule : rtcdst_shift_match

// ===== rtl/rtcdst_comp_seq.sv
/*
  Compensation sequencer: periodic and write-started correction cycles,
  temperature conversion handshake and trim update.
  Assumes the sensor answers each request with one temp_done pulse.
*/
`timescale 1ns/1ps
module rtcdst_comp_seq
  import rtcdst_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic temp_sense_enable,
  input wire rtcdst_batt_mode_type batt_mode,
  input wire logic vdd_ok,
  input wire logic wr_start,
  input wire logic sec_tick,
  input wire logic [7:0] temp_coefficient_trim,
  input wire logic [7:0] ito,
  input wire logic [4:0] compensation_control,
  // Sensor
  output logic conv_req,
  input wire logic temp_done,
  input wire logic [9:0] temp_code,
  // Result
  output rtcdst_trim_type trim,
  output logic busy
);

  typedef enum logic {S_IDLE, S_CONV} rtcdst_seq_type;

  rtcdst_seq_type state_ff;
  logic [9:0] sec_cnt_ff;
  logic [9:0] period;
  logic run_ok;
  logic start;
  logic conv_req_ff;
  logic [9:0] last_temp_ff;
  logic seen_ff;
  rtcdst_trim_type trim_ff;

  // Supply selects mode; on battery the field scales or stops the period
  always_comb begin
    // Main supply always gives the base period; the field only acts on battery
    if (vdd_ok) begin
      period = COMP_PERIOD_S;
    end else begin
      unique case (batt_mode)
        BATT_OFF: period = COMP_PERIOD_S;
        BATT_X1: period = COMP_PERIOD_S;
        BATT_X2: period = 10'(COMP_PERIOD_S << 1);
        BATT_X4: period = 10'(COMP_PERIOD_S << 2);
      endcase
    end
    run_ok = temp_sense_enable && (vdd_ok || (batt_mode != BATT_OFF));
    start = wr_start || (run_ok && sec_tick && (sec_cnt_ff >= period - SEC_ONE));
  end

  // Seconds since last cycle; restarts on each cycle start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_ff <= 10'h000;
    end else if (start || !run_ok) begin
      sec_cnt_ff <= 10'h000;
    end else if (sec_tick) begin
      sec_cnt_ff <= sec_cnt_ff + SEC_ONE;
    end
  end

  // Conversion handshake; a start during a conversion is folded into it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      conv_req_ff <= 1'b0;
    end else begin
      conv_req_ff <= 1'b0;
      unique case (state_ff)
        S_IDLE: if (start) begin
          state_ff <= S_CONV;
          conv_req_ff <= 1'b1;
        end
        S_CONV: if (temp_done) begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // New trims on the first conversion and when temperature moved since the last one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_temp_ff <= 10'h000;
      seen_ff <= 1'b0;
      trim_ff <= '0;
    end else if (state_ff == S_CONV && temp_done && (!seen_ff || temp_code != last_temp_ff)) begin
      last_temp_ff <= temp_code;
      seen_ff <= 1'b1;
      trim_ff.coarse <= ito[5:0];
      trim_ff.fine <= 8'(temp_coefficient_trim ^ temp_code[9:2]) + {3'h0, compensation_control};
    end
  end

  assign conv_req = conv_req_ff;
  assign trim = trim_ff;
  assign busy = (state_ff == S_CONV);

  chk_period_start: assert property (@(posedge clock) disable iff (!rst_n)
    (run_ok && vdd_ok && sec_tick && sec_cnt_ff == COMP_PERIOD_S - SEC_ONE && state_ff == S_IDLE)
      |=> conv_req)
    else $error("periodic correction cycle missed");

  chk_write_start: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_start && state_ff == S_IDLE) |=> (conv_req && busy))
    else $error("control write did not start a cycle");

endmodule : rtcdst_comp_seq

// ===== rtl/rtcdst_ctrl.sv
/*
  Top of the temperature compensation and seasonal shift control block:
  byte register file, factory trims, compensation sequencer and shift
  adjustment with its done flag.
  Assumes a serial front end on the same clock drives reg_wr/reg_rd for
  one cycle per byte, and a calendar core that applies hour steps.
*/
`timescale 1ns/1ps
module rtcdst_ctrl
  import rtcdst_pkg::*;
#(
  parameter logic [7:0] FACTORY_INIT_OFFSET = 8'h00,
  parameter logic [7:0] FACTORY_TEMP_COEF = 8'h00,
  parameter logic [4:0] FACTORY_TRIM_CODE = 5'h00
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port from the serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Calendar core
  input wire logic sec_tick,
  input wire rtcdst_cal_type cal,
  output logic hour_advance,
  output logic hour_retard,
  // Supply status pin
  input wire logic vdd_present,
  // Temperature sensor
  output logic temp_conv_req,
  input wire logic temp_done,
  input wire logic [9:0] temp_code,
  // Oscillator correction and status
  output rtcdst_trim_type freq_trim,
  output logic comp_busy,
  output logic seasonal_shift_done
);

  logic vdd_meta_ff;
  logic vdd_sync_ff;
  logic [7:0] init_offset_trim_ff;
  logic [7:0] temp_coefficient_trim_ff;
  logic [4:0] oscillator_trim_code_ff;
  logic [2:0] ctrl_top_ff;
  logic [7:0] forward_month_enable_ff;
  logic [7:0] forward_week_day_ff;
  logic [7:0] forward_date_ff;
  logic [7:0] forward_hour_ff;
  logic [7:0] reverse_month_ff;
  logic [7:0] reverse_week_day_ff;
  logic [7:0] reverse_date_ff;
  logic [7:0] reverse_hour_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;
  logic seasonal_shift_done_ff;
  logic hour_advance_ff;
  logic hour_retard_ff;
  logic fwd_hit;
  logic rev_hit;
  logic shift_en;
  logic ctrl_wr;
  logic do_forward;
  logic do_reverse;
  logic en_clear;

  // Supply pin crosses in from the analog monitor
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vdd_meta_ff <= 1'b0;
      vdd_sync_ff <= 1'b0;
    end else begin
      vdd_meta_ff <= vdd_present;
      vdd_sync_ff <= vdd_meta_ff;
    end
  end

  // Factory trims recalled at power-up; no write path reaches them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      init_offset_trim_ff <= FACTORY_INIT_OFFSET;
      temp_coefficient_trim_ff <= FACTORY_TEMP_COEF;
      oscillator_trim_code_ff <= FACTORY_TRIM_CODE;
    end else begin
      init_offset_trim_ff <= init_offset_trim_ff;
      temp_coefficient_trim_ff <= temp_coefficient_trim_ff;
      oscillator_trim_code_ff <= oscillator_trim_code_ff;
    end
  end

  assign ctrl_wr = reg_wr && (reg_addr == OFS_COMP_CTRL);

  // Only enable and battery-mode bits of the control byte take a write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_top_ff <= CTRL_TOP_RESET;
    end else if (ctrl_wr) begin
      ctrl_top_ff <= reg_wdata[7:TRIM_CODE_W];
    end
  end

  // Shift point registers, stored as written
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      forward_month_enable_ff <= SHIFT_REG_RESET;
      forward_week_day_ff <= SHIFT_REG_RESET;
      forward_date_ff <= SHIFT_REG_RESET;
      forward_hour_ff <= SHIFT_REG_RESET;
      reverse_month_ff <= SHIFT_REG_RESET;
      reverse_week_day_ff <= SHIFT_REG_RESET;
      reverse_date_ff <= SHIFT_REG_RESET;
      reverse_hour_ff <= SHIFT_REG_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_FWD_MONTH: forward_month_enable_ff <= reg_wdata;
        OFS_FWD_WEEKDAY: forward_week_day_ff <= reg_wdata;
        OFS_FWD_DATE: forward_date_ff <= reg_wdata;
        OFS_FWD_HOUR: forward_hour_ff <= reg_wdata;
        OFS_REV_MONTH: reverse_month_ff <= reg_wdata;
        OFS_REV_WEEKDAY: reverse_week_day_ff <= reg_wdata;
        OFS_REV_DATE: reverse_date_ff <= reg_wdata;
        OFS_REV_HOUR: reverse_hour_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux; the control byte shows the locked trim code in its low bits
  always_comb begin
    unique case (reg_addr)
      OFS_INIT_OFFSET: nxt_rdata = init_offset_trim_ff;
      OFS_TEMP_COEF: nxt_rdata = temp_coefficient_trim_ff;
      OFS_COMP_CTRL: nxt_rdata = {ctrl_top_ff, oscillator_trim_code_ff};
      OFS_FWD_MONTH: nxt_rdata = forward_month_enable_ff;
      OFS_FWD_WEEKDAY: nxt_rdata = forward_week_day_ff;
      OFS_FWD_DATE: nxt_rdata = forward_date_ff;
      OFS_FWD_HOUR: nxt_rdata = forward_hour_ff;
      OFS_REV_MONTH: nxt_rdata = reverse_month_ff;
      OFS_REV_WEEKDAY: nxt_rdata = reverse_week_day_ff;
      OFS_REV_DATE: nxt_rdata = reverse_date_ff;
      OFS_REV_HOUR: nxt_rdata = reverse_hour_ff;
      default: nxt_rdata = READ_ZERO;
    endcase
  end

  // Read data held until the next read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  rtcdst_comp_seq u_comp_seq (
    .clock(clock),
    .rst_n(rst_n),
    .temp_sense_enable(ctrl_top_ff[CTRL_TSE_BIT - TRIM_CODE_W]),
    .batt_mode(rtcdst_batt_mode_type'(ctrl_top_ff[CTRL_BATT_LSB - TRIM_CODE_W +: 2])),
    .vdd_ok(vdd_sync_ff),
    .wr_start(ctrl_wr && reg_wdata[CTRL_TSE_BIT]),
    .sec_tick(sec_tick),
    .temp_coefficient_trim(temp_coefficient_trim_ff),
    .ito(init_offset_trim_ff),
    .compensation_control(oscillator_trim_code_ff),
    .conv_req(temp_conv_req),
    .temp_done(temp_done),
    .temp_code(temp_code),
    .trim(freq_trim),
    .busy(comp_busy)
  );

  rtcdst_shift_match u_fwd_match (
    .cal(cal),
    .month_reg(forward_month_enable_ff),
    .week_day_reg(forward_week_day_ff),
    .date_reg(forward_date_ff),
    .hour_reg(forward_hour_ff),
    .hit(fwd_hit)
  );

  rtcdst_shift_match u_rev_match (
    .cal(cal),
    .month_reg(reverse_month_ff),
    .week_day_reg(reverse_week_day_ff),
    .date_reg(reverse_date_ff),
    .hour_reg(reverse_hour_ff),
    .hit(rev_hit)
  );

  // The done flag gates direction: after a set back the repeated hour
  // cannot match the reverse point a second time
  always_comb begin
    shift_en = forward_month_enable_ff[MONTH_EN_BIT];
    do_forward = shift_en && sec_tick && fwd_hit && !seasonal_shift_done_ff;
    do_reverse = shift_en && sec_tick && rev_hit && seasonal_shift_done_ff;
    en_clear = reg_wr && (reg_addr == OFS_FWD_MONTH) && !reg_wdata[MONTH_EN_BIT];
  end

  // Done flag; a forward shift in the same cycle as a disable still sets it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seasonal_shift_done_ff <= 1'b0;
    end else if (do_forward) begin
      seasonal_shift_done_ff <= 1'b1;
    end else if (do_reverse || en_clear) begin
      seasonal_shift_done_ff <= 1'b0;
    end
  end

  // One-cycle hour step requests to the calendar core
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hour_advance_ff <= 1'b0;
      hour_retard_ff <= 1'b0;
    end else begin
      hour_advance_ff <= do_forward;
      hour_retard_ff <= do_reverse;
    end
  end

  assign hour_advance = hour_advance_ff;
  assign hour_retard = hour_retard_ff;
  assign seasonal_shift_done = seasonal_shift_done_ff;

  chk_trim_locked: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_wr |=> (oscillator_trim_code_ff == $past(oscillator_trim_code_ff)))
    else $error("trim code changed by a write");

  chk_ro_trims: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && (reg_addr == OFS_INIT_OFFSET || reg_addr == OFS_TEMP_COEF))
      |=> $stable(init_offset_trim_ff) && $stable(temp_coefficient_trim_ff))
    else $error("read-only trim register changed");

  chk_ctrl_read: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_COMP_CTRL && !reg_wr)
      |=> (reg_rdata[TRIM_CODE_W-1:0] == FACTORY_TRIM_CODE))
    else $error("control read lost the trim code");

  chk_tse_store: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_wr |=> (ctrl_top_ff == $past(reg_wdata[7:TRIM_CODE_W])))
    else $error("enable bits not stored");

  chk_done_set: assert property (@(posedge clock) disable iff (!rst_n)
    hour_advance |-> seasonal_shift_done && !hour_retard)
    else $error("forward shift without done flag");

  chk_done_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (hour_retard || $past(en_clear && !do_forward)) |-> !seasonal_shift_done)
    else $error("done flag not cleared");

  chk_shift_gated: assert property (@(posedge clock) disable iff (!rst_n)
    (hour_advance || hour_retard) |-> $past(shift_en && sec_tick))
    else $error("shift without enable");

  // Factory bytes read back unchanged; no write path reaches them
  chk_offset_read: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_INIT_OFFSET) |=> (reg_rdata == FACTORY_INIT_OFFSET))
    else $error("offset trim read wrong");

  chk_coef_read: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_TEMP_COEF) |=> (reg_rdata == FACTORY_TEMP_COEF))
    else $error("coefficient trim read wrong");

  // Shift point bytes keep all eight bits, enable and select bits included
  chk_fwd_stored: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_FWD_MONTH) |=> (forward_month_enable_ff == $past(reg_wdata)))
    else $error("forward month byte not stored");

  chk_select_stored: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_FWD_WEEKDAY) |=> (forward_week_day_ff == $past(reg_wdata)))
    else $error("forward week and day byte not stored");

  // Direction follows the flag: forward only from clear, reverse only from set
  chk_fwd_from_clear: assert property (@(posedge clock) disable iff (!rst_n)
    hour_advance |-> !$past(seasonal_shift_done))
    else $error("forward shift while flag already set");

  chk_rev_from_set: assert property (@(posedge clock) disable iff (!rst_n)
    hour_retard |-> $past(seasonal_shift_done))
    else $error("reverse shift while flag clear");

  // No step while disabled; no advance in the cycle right after an advance
  chk_no_shift_off: assert property (@(posedge clock) disable iff (!rst_n)
    !shift_en |=> (!hour_advance && !hour_retard))
    else $error("hour step while shifts disabled");

  chk_single_step: assert property (@(posedge clock) disable iff (!rst_n)
    hour_advance |=> !hour_advance)
    else $error("hour advanced twice in a row");

  // Trims move only at the end of a conversion that was asked for
  chk_req_busy: assert property (@(posedge clock) disable iff (!rst_n)
    temp_conv_req |-> comp_busy)
    else $error("conversion request while sequencer idle");

  chk_trim_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !comp_busy |=> $stable(freq_trim))
    else $error("trim changed outside a conversion");

endmodule : rtcdst_ctrl

// ===== dv/rtcdst_sensor_model.sv
/*
  Temperature sensor stand-in for the compensation sequencer: answers each
  conversion request with one done pulse and a result after a chosen delay.
  Assumes requests are one-cycle pulses launched by the rising clock edge.
*/
`timescale 1ns/1ps
module rtcdst_sensor_model (
  // Clock and request
  input wire logic clock,
  input wire logic conv_req,
  // Delay and result chosen by the bench
  input wire logic [7:0] delay,
  input wire logic [9:0] code,
  // Answer
  output logic done,
  output logic [9:0] code_out
);
  logic [9:0] last_code;

  // One request at a time; outside the done cycle the result is scrambled
  // so that a late sample never reads a stale but plausible value
  initial begin
    done = 1'b0;
    code_out = 10'h3FF;
    last_code = 10'h000;
    forever begin
      @(posedge clock);
      if (conv_req) begin
        repeat (delay) @(posedge clock);
        @(negedge clock);
        done = 1'b1;
        code_out = code;
        last_code = code;
        @(negedge clock);
        done = 1'b0;
        code_out = ~last_code;
      end
    end
  end
endmodule : rtcdst_sensor_model

// ===== dv/rtcdst_ctrl_bench.sv
/*
  Self-checking bench of the compensation and seasonal shift control top:
  register map, trim locks, correction timing and shift adjustments.
  Assumes the sensor model above and inputs driven on the falling edge.
*/
`timescale 1ns/1ps
module rtcdst_ctrl_bench;
  import rtcdst_pkg::*;
  localparam logic [7:0] F_ITO = 8'h2A;
  localparam logic [7:0] F_COEF = 8'h5C;
  localparam logic [4:0] F_TRIM = 5'h13;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic sec_tick = 1'b0;
  logic vdd_present = 1'b1;
  rtcdst_cal_type cal = '0;
  logic [7:0] sens_dly = 8'h02;
  logic [9:0] sens_code = 10'h1B5;
  logic [7:0] reg_rdata;
  logic hour_advance, hour_retard, temp_conv_req, temp_done, comp_busy, seasonal_shift_done;
  logic [9:0] temp_code;
  rtcdst_trim_type freq_trim;
  rtcdst_trim_type exp_trim;
  logic [7:0] rd_val;
  logic conv_seen, adv_seen, ret_seen;
  int n_mismatch = 0;
  int checks_done = 0;
  int model_reg [256];
  int hit;
  int pv [5] = '{1, 0, 0, 0, 0};
  int pm [5] = '{3, 0, 1, 2, 3};
  int pp [5] = '{60, 0, 60, 120, 240};
  int dst_val [8] = '{'h84, 'h48, 'h00, 'h02, 'h10, 'h78, 'h00, 'h02};

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  rtcdst_ctrl #(.FACTORY_INIT_OFFSET(F_ITO), .FACTORY_TEMP_COEF(F_COEF), .FACTORY_TRIM_CODE(F_TRIM)) dut_u (
    .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sec_tick(sec_tick), .cal(cal),
    .hour_advance(hour_advance), .hour_retard(hour_retard), .vdd_present(vdd_present),
    .temp_conv_req(temp_conv_req), .temp_done(temp_done), .temp_code(temp_code),
    .freq_trim(freq_trim), .comp_busy(comp_busy), .seasonal_shift_done(seasonal_shift_done));

  rtcdst_sensor_model sens_u (.clock(clock), .conv_req(temp_conv_req), .delay(sens_dly),
    .code(sens_code), .done(temp_done), .code_out(temp_code));

  task automatic print_verdict;
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // Compare tasks, one per kind of result
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask : chk8

  task automatic chk1(input string name, input logic exp, input logic got);
    chk8(name, {7'h00, exp}, {7'h00, got});
  endtask : chk1

  task automatic chk_trim(input rtcdst_trim_type exp);
    checks_done++;
    if (freq_trim !== exp) begin
      $display("BAD freq_trim expected %h seen %h", exp, freq_trim);
      n_mismatch++;
    end
  endtask : chk_trim

  // Register writes also update the model: trim code and read-only bytes keep their value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    conv_seen = temp_conv_req;
    if (a >= OFS_FWD_MONTH && a <= OFS_REV_HOUR) model_reg[a] = d;
    if (a == OFS_COMP_CTRL) model_reg[a] = (d & 8'hE0) | {3'h0, F_TRIM};
  endtask : wr

  // Read data is sampled half a cycle after the read edge
  task automatic rd_cmp(input logic [7:0] a);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
    chk8("reg_rdata", 8'(model_reg[a]), rd_val);
  endtask : rd_cmp

  task automatic tick;
    @(negedge clock);
    sec_tick = 1'b1;
    @(negedge clock);
    sec_tick = 1'b0;
    conv_seen = temp_conv_req;
    adv_seen = hour_advance;
    ret_seen = hour_retard;
  endtask : tick

  // Bounded wait for the sequencer to go idle
  task automatic wait_idle;
    for (int i = 0; i < 60 && comp_busy !== 1'b0; i++) @(negedge clock);
    if (comp_busy !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wait_idle

  task automatic set_cal(input logic [7:0] m, input logic [7:0] d, input logic [2:0] wd, input logic [4:0] md);
    cal = '{month: m, date: d, hour: 8'h02, minute: 8'h00, second: 8'h00, weekday: wd, month_days: md};
  endtask : set_cal

  initial begin
    void'($urandom(15593));
    model_reg = '{default: 0};
    model_reg[OFS_INIT_OFFSET] = F_ITO;
    model_reg[OFS_TEMP_COEF] = F_COEF;
    model_reg[OFS_COMP_CTRL] = {3'h0, F_TRIM};
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    // Power-up values, read-only trims and locked trim code
    chk1("done", 1'b0, seasonal_shift_done);
    foreach (pv[i]) rd_cmp(OFS_INIT_OFFSET + 8'(i % 3));
    wr(OFS_INIT_OFFSET, 8'($urandom));
    wr(OFS_TEMP_COEF, 8'($urandom));
    wr(OFS_COMP_CTRL, 8'($urandom) & 8'h1F);
    wr(8'h30, 8'($urandom));
    for (int a = 'h0B; a <= 'h0D; a++) rd_cmp(8'(a));
    rd_cmp(8'h30);
    for (int a = 'h15; a <= 'h1C; a++) wr(8'(a), 8'($urandom));
    for (int a = 'h15; a <= 'h1C; a++) rd_cmp(8'(a));
    $display("test registers done");
    // Read-modify-write enable starts a correction cycle
    rd_cmp(OFS_COMP_CTRL);
    wr(OFS_COMP_CTRL, (rd_val & 8'h1F) | 8'hA0);
    chk1("temp_conv_req", 1'b1, conv_seen);
    wait_idle();
    exp_trim = '{coarse: F_ITO[5:0], fine: (F_COEF ^ sens_code[9:2]) + {3'h0, F_TRIM}};
    chk_trim(exp_trim);
    rd_cmp(OFS_COMP_CTRL);
    wr(OFS_COMP_CTRL, 8'h00);
    chk1("temp_conv_req", 1'b0, conv_seen);
    $display("test enable done");
    // Correction period per supply state and battery mode, sensor slower now
    sens_dly = 8'h0A;
    for (int i = 0; i < 5; i++) begin
      vdd_present = pv[i][0];
      repeat (3) @(negedge clock);
      wr(OFS_COMP_CTRL, 8'h80 | 8'(pm[i] << 5));
      wait_idle();
      hit = 0;
      for (int t = 1; t <= 250 && hit == 0; t++) begin
        tick();
        if (conv_seen === 1'b1) hit = t;
      end
      chk8("period", 8'(pp[i]), 8'(hit));
      wait_idle();
    end
    vdd_present = 1'b1;
    $display("test period done");
    // Seasonal shift: forward, repeat refused, reverse on last weekday only
    foreach (dst_val[i]) wr(8'h15 + 8'(i), 8'(dst_val[i]));
    set_cal(8'h04, 8'h01, 3'h0, 5'd30);
    tick();
    chk1("hour_advance", 1'b1, adv_seen);
    chk1("done", 1'b1, seasonal_shift_done);
    tick();
    chk1("hour_advance", 1'b0, adv_seen);
    set_cal(8'h10, 8'h20, 3'h0, 5'd31);
    tick();
    chk1("hour_retard", 1'b0, ret_seen);
    set_cal(8'h10, 8'h27, 3'h0, 5'd31);
    tick();
    chk1("hour_retard", 1'b1, ret_seen);
    chk1("done", 1'b0, seasonal_shift_done);
    set_cal(8'h04, 8'h01, 3'h0, 5'd30);
    tick();
    wr(OFS_FWD_MONTH, 8'h04);
    chk1("done", 1'b0, seasonal_shift_done);
    tick();
    chk1("hour_advance", 1'b0, adv_seen);
    // Date matching instead of week and day
    wr(OFS_FWD_MONTH, 8'h84);
    wr(OFS_FWD_WEEKDAY, 8'h00);
    wr(OFS_FWD_DATE, 8'h05);
    set_cal(8'h04, 8'h05, 3'h3, 5'd30);
    tick();
    chk1("hour_advance", 1'b1, adv_seen);
    $display("test seasonal done");
    print_verdict();
  end
endmodule : rtcdst_ctrl_bench
